//--- status_regset.sv
// Status reporting package and one latched event register set.
// Assumes one instrument clock; set strobes come from logic on that clock.
`timescale 1ns/1ns
`default_nettype none

package status_pkg;
    localparam int REG_W = 8;
    localparam int BCD_W = 12;
    // Standard event bit positions
    localparam int STD_POWER_ON = 7;
    localparam int STD_CMD_ERR = 5;
    localparam int STD_EXE_ERR = 4;
    localparam int STD_QRY_ERR = 2;
    localparam int STD_OP_DONE = 0;
    localparam logic [7:0] STD_USED_MASK = 8'hB5;
    // Operation event bit positions
    localparam int OP_CAL_ERR = 6;
    localparam int OP_RAMP_DONE = 5;
    localparam int OP_LOG_DONE = 4;
    localparam int OP_ALARM = 3;
    localparam int OP_NEW_READING = 2;
    localparam int OP_OVERLOAD = 1;
    localparam int OP_NO_PROBE = 0;
    localparam int OP_COND_W = 7;
    localparam logic [7:0] OP_USED_MASK = 8'h7F;
    // Status byte bit positions
    localparam int STB_OP_SUMMARY = 7;
    localparam int STB_MASTER = 6;
    localparam int STB_STD_SUMMARY = 5;
    localparam int STB_MSG_AVAIL = 4;
    localparam logic [7:0] SRE_USED_MASK = 8'hB0;
    // Values after reset
    localparam logic [7:0] EVENT_RESET = 8'h00;
    localparam logic [7:0] ENABLE_RESET = 8'h00;

    typedef enum logic [3:0] {
        CMD_CLEAR_STATUS,
        CMD_STD_ENABLE_WRITE,
        CMD_STD_ENABLE_READ,
        CMD_STD_EVENT_READ_CLEAR,
        CMD_SRQ_ENABLE_WRITE,
        CMD_SRQ_ENABLE_READ,
        CMD_STATUS_BYTE_READ,
        CMD_OP_COMPLETE_ARM,
        CMD_OPERATION_ENABLE_WRITE,
        CMD_OPERATION_ENABLE_READ,
        CMD_OPERATION_EVENT_READ_CLEAR,
        CMD_OPERATION_CONDITION_READ
    } cmd_code_t;

    typedef struct packed {
        logic valid;
        cmd_code_t code;
        logic [7:0] value;
    } cmd_t;

    typedef struct packed {
        logic command_error_flag;
        logic execution_error_flag;
        logic query_error_flag;
    } std_evt_t;

    typedef struct packed {
        logic valid;
        logic [7:0] value;
        logic [11:0] bcd;
    } resp_t;
endpackage

module event_reg_set #(
    parameter int WIDTH = 8,
    parameter logic [7:0] USED_MASK = 8'hFF
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [WIDTH-1:0] i_set,
    input wire logic i_clear,
    input wire logic i_enable_we,
    input wire logic [WIDTH-1:0] i_enable_wdata,
    output logic [WIDTH-1:0] o_event_q,
    output logic [WIDTH-1:0] o_enable_q,
    output logic o_summary
);
    logic [WIDTH-1:0] event_d;
    logic [WIDTH-1:0] used;

    assign used = USED_MASK[WIDTH-1:0];
    // A set arriving with the clear survives, so no event is lost
    assign event_d = ((i_clear ? '0 : o_event_q) | i_set) & used; // R23
    assign o_summary = |(o_event_q & o_enable_q);

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_event_q <= status_pkg::EVENT_RESET[WIDTH-1:0];
            o_enable_q <= status_pkg::ENABLE_RESET[WIDTH-1:0];
        end else begin
            o_event_q <= event_d;
            if (i_enable_we) begin
                o_enable_q <= i_enable_wdata & used;
            end
        end
    end

    a_set_wins: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R23
        |(i_set & used) |=> ((o_event_q & $past(i_set)) == ($past(i_set) & used)))
        else $error("event set lost");
    a_clear_empties: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R7 R8
        i_clear && !(|i_set) |=> o_event_q == '0)
        else $error("event clear failed");
endmodule

`default_nettype wire

//--- status_service.sv
// Status byte, service request and command handling for two event sets.
// Assumes decoded commands, serial poll and event strobes on the instrument clock.
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// R1 - Status byte is read-only and follows the set summaries continuously.
// R2 - Enabled summaries ORed form master summary, driving service request.
// R3 - Service request enable mask is written and read back unchanged.
// R4 - Query answers carry the binary-weighted value, also as decimal digits.
// R5 - Only enable masks are writable; other status registers are read-only.
// R6 - Condition register has no clearing action; it is live.
// R7 - Querying an event register clears that register.
// R8 - Clear-status command clears both event registers and their summaries.
// R9 - Writing zero clears a mask; reset clears masks, events, status byte.
// R10 - No direct status byte clear; summary drops when its events clear.
// R11 - Standard flags: power-on 7, command 5, execution 4, query 2, done 0.
// R12 - Command error flag sets on parse or unsupported command errors.
// R13 - Execution error flag sets on requests beyond capability.
// R14 - Query error flag sets when response data is lost to full queue.
// R15 - Done flag sets after arming once pending operations finish.
// R16 - Standard enable written and read; standard events read then cleared.
// R17 - Standard flags ANDed with enable form the standard summary.
// R18 - Operation flags: calibration 6, ramp 5, log 4, alarm 3, reading 2.
// R19 - Calibration error flag sets when uncalibrated or data corrupted.
// R20 - Operation enable write/read, event read-clear, live condition read.
// R21 - Operation flags ANDed with enable form the operation summary.
// R22 - Status byte query reports master summary without clearing.
// R23 - Event bits latch, ignore repeats, hold until read-clear or clear.
// R24 - Status byte: operation 7, master 6, standard 5, message 4.
// R25 - Service request asserts only on master summary rising edge.
// R26 - Serial poll clears request service, master summary remains.
// R27 - Undefined bits read zero; matching enable writes are ignored.
// R28 - Summaries and status byte are recomputed every clock cycle.
module status_service (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire status_pkg::cmd_t i_cmd,
    input wire status_pkg::std_evt_t i_std_evt,
    input wire logic i_ops_idle,
    input wire logic [6:0] i_op_cond,
    input wire logic i_msg_available,
    input wire logic i_serial_poll,
    output var status_pkg::resp_t o_resp,
    output logic [7:0] o_poll_byte,
    output logic o_poll_valid,
    output logic o_srq
);
    logic [7:0] std_set;
    logic [7:0] std_event_q;
    logic [7:0] std_enable_q;
    logic std_summary;
    logic [7:0] op_set;
    logic [7:0] op_event_q;
    logic [7:0] op_enable_q;
    logic op_summary;
    logic [7:0] sre_q;
    logic [7:0] status_byte;
    logic [7:0] summary_bits;
    logic master_summary_bit;
    logic master_prev_q;
    logic request_service_bit_q;
    logic request_service_bit_d;
    logic power_on_pending_q;
    logic done_armed_q;
    logic done_armed_d;
    logic done_fire;
    logic [6:0] cond_prev_q;
    logic cmd_cls;
    logic std_read_clear;
    logic op_read_clear;
    logic std_enable_we;
    logic op_enable_we;
    logic sre_we;
    logic [7:0] answer_value;
    logic answer_valid;
    status_pkg::resp_t resp_d;
    logic [7:0] op_condition;

    function automatic logic [11:0] to_bcd(input logic [7:0] bin);
        logic [19:0] s;
        s = {12'h000, bin};
        for (int i = 0; i < 8; i++) begin
            if (s[11:8] > 4'h4) s[11:8] = s[11:8] + 4'h3;
            if (s[15:12] > 4'h4) s[15:12] = s[15:12] + 4'h3;
            if (s[19:16] > 4'h4) s[19:16] = s[19:16] + 4'h3;
            s = {s[18:0], 1'b0};
        end
        return s[19:8];
    endfunction

    // Command decode
    assign cmd_cls = i_cmd.valid && i_cmd.code == status_pkg::CMD_CLEAR_STATUS;
    assign std_read_clear = i_cmd.valid && i_cmd.code == status_pkg::CMD_STD_EVENT_READ_CLEAR; // R7
    assign op_read_clear = i_cmd.valid && i_cmd.code == status_pkg::CMD_OPERATION_EVENT_READ_CLEAR; // R7
    // Only masks have write commands; everything else has no write path
    assign std_enable_we = i_cmd.valid && i_cmd.code == status_pkg::CMD_STD_ENABLE_WRITE; // R5
    assign op_enable_we = i_cmd.valid && i_cmd.code == status_pkg::CMD_OPERATION_ENABLE_WRITE; // R5
    assign sre_we = i_cmd.valid && i_cmd.code == status_pkg::CMD_SRQ_ENABLE_WRITE; // R3

    // Operation-complete arming
    assign done_fire = done_armed_q && i_ops_idle; // R15
    assign done_armed_d = (i_cmd.valid && i_cmd.code == status_pkg::CMD_OP_COMPLETE_ARM) ? 1'b1 :
                          (done_fire ? 1'b0 : done_armed_q);

    // Standard event strobes
    always_comb begin
        std_set = 8'h00;
        std_set[status_pkg::STD_POWER_ON] = power_on_pending_q; // R11
        std_set[status_pkg::STD_CMD_ERR] = i_std_evt.command_error_flag; // R12
        std_set[status_pkg::STD_EXE_ERR] = i_std_evt.execution_error_flag; // R13
        std_set[status_pkg::STD_QRY_ERR] = i_std_evt.query_error_flag; // R14
        std_set[status_pkg::STD_OP_DONE] = done_fire; // R15
    end

    // Operation events latch on the rising edge of each live condition
    assign op_condition = {1'b0, i_op_cond}; // R6 R27
    assign op_set = {1'b0, i_op_cond & ~cond_prev_q}; // R18 R19

    event_reg_set #(.WIDTH(8), .USED_MASK(status_pkg::STD_USED_MASK)) u_std (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_set(std_set),
        .i_clear(std_read_clear || cmd_cls), // R8 R16
        .i_enable_we(std_enable_we),
        .i_enable_wdata(i_cmd.value),
        .o_event_q(std_event_q),
        .o_enable_q(std_enable_q),
        .o_summary(std_summary) // R17
    );

    event_reg_set #(.WIDTH(8), .USED_MASK(status_pkg::OP_USED_MASK)) u_op (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_set(op_set),
        .i_clear(op_read_clear || cmd_cls), // R8 R20
        .i_enable_we(op_enable_we),
        .i_enable_wdata(i_cmd.value),
        .o_event_q(op_event_q),
        .o_enable_q(op_enable_q),
        .o_summary(op_summary) // R21
    );

    // Status byte: unlatched, rebuilt every cycle
    always_comb begin
        summary_bits = 8'h00;
        summary_bits[status_pkg::STB_OP_SUMMARY] = op_summary; // R1 R24 R28
        summary_bits[status_pkg::STB_STD_SUMMARY] = std_summary; // R10
        summary_bits[status_pkg::STB_MSG_AVAIL] = i_msg_available;
    end
    assign master_summary_bit = |(summary_bits & sre_q); // R2
    assign status_byte = summary_bits | ({7'h00, master_summary_bit} << status_pkg::STB_MASTER); // R22

    // Request service latches on the master rising edge, poll clears it
    assign request_service_bit_d = (master_summary_bit && !master_prev_q) ? 1'b1 : // R25
                                   (i_serial_poll ? 1'b0 : request_service_bit_q); // R26
    assign o_srq = request_service_bit_q; // R2

    // Query answer select
    always_comb begin
        answer_valid = i_cmd.valid;
        case (i_cmd.code)
            status_pkg::CMD_STD_ENABLE_READ: answer_value = std_enable_q; // R16
            status_pkg::CMD_STD_EVENT_READ_CLEAR: answer_value = std_event_q; // R16
            status_pkg::CMD_SRQ_ENABLE_READ: answer_value = sre_q; // R3
            status_pkg::CMD_STATUS_BYTE_READ: answer_value = status_byte; // R22
            status_pkg::CMD_OPERATION_ENABLE_READ: answer_value = op_enable_q; // R20
            status_pkg::CMD_OPERATION_EVENT_READ_CLEAR: answer_value = op_event_q; // R20
            status_pkg::CMD_OPERATION_CONDITION_READ: answer_value = op_condition; // R20
            default: begin
                answer_value = 8'h00;
                answer_valid = 1'b0;
            end
        endcase
    end

    always_comb begin
        resp_d.valid = answer_valid;
        resp_d.value = answer_value; // R4
        resp_d.bcd = to_bcd(answer_value); // R4
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            sre_q <= status_pkg::ENABLE_RESET; // R9
            master_prev_q <= 1'b0;
            request_service_bit_q <= 1'b0;
            power_on_pending_q <= 1'b1; // R11
            done_armed_q <= 1'b0;
            cond_prev_q <= 7'h00;
            o_resp <= '0;
            o_poll_byte <= 8'h00;
            o_poll_valid <= 1'b0;
        end else begin
            if (sre_we) begin
                sre_q <= i_cmd.value & status_pkg::SRE_USED_MASK; // R3 R27
            end
            master_prev_q <= master_summary_bit;
            request_service_bit_q <= request_service_bit_d;
            power_on_pending_q <= 1'b0;
            done_armed_q <= done_armed_d;
            cond_prev_q <= i_op_cond;
            o_resp <= resp_d;
            o_poll_valid <= i_serial_poll;
            if (i_serial_poll) begin
                // Poll reports the request function in bit 6
                o_poll_byte <= summary_bits | ({7'h00, request_service_bit_q} << status_pkg::STB_MASTER); // R26
            end
        end
    end

    // Checks
    a_srq_rise_only: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R25
        $rose(o_srq) |-> $past(master_summary_bit) && !$past(master_prev_q))
        else $error("service request without master rise");
    a_poll_clears_request: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R26
        i_serial_poll && !(master_summary_bit && !master_prev_q) |=> !o_srq)
        else $error("poll left request set");
    // Built from the summaries and mask bits by position, not from the decode expression
    a_master_summary: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R2
        status_byte[status_pkg::STB_MASTER] == ((op_summary && sre_q[status_pkg::STB_OP_SUMMARY])
        || (std_summary && sre_q[status_pkg::STB_STD_SUMMARY])
        || (i_msg_available && sre_q[status_pkg::STB_MSG_AVAIL])))
        else $error("master summary mismatch");
    a_std_read_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R7
        std_read_clear && !(|std_set) |=> std_event_q == 8'h00 && o_resp.value == $past(std_event_q))
        else $error("standard read-clear wrong");
    a_cls_clears_both: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R8
        cmd_cls && !(|std_set) && !(|op_set) |=> std_event_q == 8'h00 && op_event_q == 8'h00)
        else $error("clear status failed");
    // Host leaves one idle cycle between commands, so the read follows the write by two
    a_sre_readback: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R3
        sre_we ##1 !sre_we ##1 (i_cmd.valid && i_cmd.code == status_pkg::CMD_SRQ_ENABLE_READ)
        |=> o_resp.value == ($past(i_cmd.value, 3) & status_pkg::SRE_USED_MASK))
        else $error("enable readback wrong");
    a_power_on_flag: assert property (@(posedge i_clk) // R11
        $fell(i_sys_rst) |=> std_event_q[status_pkg::STD_POWER_ON])
        else $error("power-on flag missing");
    a_reset_clears: assert property (@(posedge i_clk) // R9
        i_sys_rst |=> sre_q == 8'h00 && op_enable_q == 8'h00 && !o_srq)
        else $error("reset left state");
    // A fresh arm in the firing cycle re-arms on purpose
    a_done_fire: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R15
        done_armed_q && i_ops_idle && !(i_cmd.valid && i_cmd.code == status_pkg::CMD_OP_COMPLETE_ARM)
        |=> std_event_q[status_pkg::STD_OP_DONE] && !done_armed_q)
        else $error("completion flag missed");
    a_op_latch: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R23
        $rose(i_op_cond[status_pkg::OP_ALARM]) ##1 (!op_read_clear && !cmd_cls)
        |=> op_event_q[status_pkg::OP_ALARM])
        else $error("operation event not held");
    a_unused_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R27
        (std_event_q & ~status_pkg::STD_USED_MASK) == 8'h00 && op_event_q[7] == 1'b0
        && status_byte[3:0] == 4'h0)
        else $error("undefined bit set");

    c_srq_raised: cover property (@(posedge i_clk) disable iff (i_sys_rst) $rose(o_srq));
    c_poll_after_srq: cover property (@(posedge i_clk) disable iff (i_sys_rst) o_srq ##[1:20] i_serial_poll);
    c_std_readclear: cover property (@(posedge i_clk) disable iff (i_sys_rst)
        std_read_clear && std_event_q != 8'h00);
    c_done_fire: cover property (@(posedge i_clk) disable iff (i_sys_rst) done_fire);
endmodule

`default_nettype wire

//--- srq_poller.sv
// Bus controller model that answers a service request with a serial poll.
// Assumes the instrument clock; the poll is a one-cycle pulse after a delay.
`timescale 1ns/1ns
`default_nettype none

module srq_poller #(
    parameter int DELAY = 3
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_srq,
    output logic o_poll
);
    logic [3:0] wait_q;

    // Controller only polls once it has seen the line high for a while, so a slow host is modelled
    // It never touches status registers; mask writes come from the host program alone
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || !i_srq || o_poll) begin
            wait_q <= 4'h0;
            o_poll <= 1'b0;
        end else begin
            wait_q <= wait_q + 4'h1;
            o_poll <= (wait_q == 4'(DELAY));
        end
    end
endmodule

`default_nettype wire

//--- status_service_tb.sv
// Self-checking bench for the status byte and service request block.
// Assumes a controller model that serial polls whenever the request line is up.
`timescale 1ns/1ns
`default_nettype none

module status_service_tb;
    logic i_clk, i_sys_rst, i_ops_idle, i_msg_available, i_serial_poll, o_poll_valid, o_srq;
    status_pkg::cmd_t i_cmd;
    status_pkg::std_evt_t i_std_evt;
    logic [6:0] i_op_cond;
    status_pkg::resp_t o_resp;
    logic [7:0] o_poll_byte, std_ev, op_ev, ese, sre, ope;
    int miscompares, num_checks;

    status_service status_service_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cmd(i_cmd),
        .i_std_evt(i_std_evt), .i_ops_idle(i_ops_idle), .i_op_cond(i_op_cond),
        .i_msg_available(i_msg_available), .i_serial_poll(i_serial_poll), .o_resp(o_resp),
        .o_poll_byte(o_poll_byte), .o_poll_valid(o_poll_valid), .o_srq(o_srq));
    srq_poller srq_poller_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_srq(o_srq), .o_poll(i_serial_poll));

    function automatic logic [7:0] summ();
        summ = {|(op_ev & ope), 1'b0, |(std_ev & ese), i_msg_available, 4'h0};
    endfunction
    function automatic logic [7:0] stb();
        stb = summ() | {1'b0, |(summ() & sre & 8'hB0), 6'h00};
    endfunction
    function automatic logic [11:0] bcd(input logic [7:0] v);
        bcd = {4'(v / 100), 4'(v / 10 % 10), 4'(v % 10)};
    endfunction

    task automatic test_done();
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_resp(input logic [7:0] exp);
        num_checks++;
        if ({o_resp.valid, o_resp.value, o_resp.bcd} !== {1'b1, exp, bcd(exp)}) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, o_resp, {1'b1, exp, bcd(exp)});
        end
    endtask
    // Answer stands only in the cycle after the taking edge, so it is sampled there
    task automatic send(input status_pkg::cmd_code_t c, input logic [7:0] v);
        @(posedge i_clk);
        i_cmd <= {1'b1, c, v};
        @(posedge i_clk);
        i_cmd <= '0;
        #1;
    endtask
    task automatic query(input status_pkg::cmd_code_t c, input logic [7:0] exp);
        send(c, 8'h00);
        chk_resp(exp);
    endtask
    task automatic mask(input status_pkg::cmd_code_t w, input status_pkg::cmd_code_t r,
                        input logic [7:0] used, output logic [7:0] m);
        m = 8'($urandom);
        send(w, m);
        m &= used;
        query(r, m);
    endtask
    task automatic pulse(input logic [2:0] e);
        @(posedge i_clk);
        i_std_evt <= e;
        @(posedge i_clk);
        i_std_evt <= '0;
        std_ev |= {2'b00, e[2], e[1], 1'b0, e[0], 2'b00};
    endtask
    task automatic cond(input logic [6:0] c);
        @(posedge i_clk);
        op_ev |= {1'b0, c & ~i_op_cond};
        i_op_cond <= c;
    endtask
    task automatic wait_poll(input logic [7:0] exp);
        int n;
        n = 0;
        do begin
            @(posedge i_clk);
            #1;
            n++;
        end while (o_poll_valid !== 1'b1 && n < 20);
        chk_val({7'h00, o_poll_valid}, 8'h01);
        chk_val(o_poll_byte, exp);
        chk_val({7'h00, o_srq}, 8'h00);
    endtask

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // Whole run is near one thousand cycles; twenty thousand means a hang
    initial begin
        #200000;
        miscompares++;
        test_done();
    end

    initial begin
        {i_sys_rst, i_cmd, i_std_evt, i_ops_idle, i_op_cond, i_msg_available} = '0;
        i_sys_rst = 1'b1;
        {op_ev, ese, sre, ope} = '0;
        std_ev = 8'h80;
        void'($urandom(77028));
        repeat (8) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        repeat (3) @(posedge i_clk);
        query(status_pkg::CMD_STD_EVENT_READ_CLEAR, 8'h80);
        std_ev = 8'h00;
        query(status_pkg::CMD_STD_EVENT_READ_CLEAR, 8'h00);
        query(status_pkg::CMD_SRQ_ENABLE_READ, 8'h00);
        query(status_pkg::CMD_OPERATION_ENABLE_READ, 8'h00);
        for (int i = 0; i < 40; i++) begin
            mask(status_pkg::CMD_STD_ENABLE_WRITE, status_pkg::CMD_STD_ENABLE_READ, 8'hB5, ese);
            mask(status_pkg::CMD_SRQ_ENABLE_WRITE, status_pkg::CMD_SRQ_ENABLE_READ, 8'hB0, sre);
            mask(status_pkg::CMD_OPERATION_ENABLE_WRITE, status_pkg::CMD_OPERATION_ENABLE_READ, 8'h7F, ope);
            pulse(3'($urandom));
            cond(7'($urandom));
            @(posedge i_clk);
            i_msg_available <= 1'($urandom);
            @(posedge i_clk);
            query(status_pkg::CMD_STATUS_BYTE_READ, stb());
            query(status_pkg::CMD_OPERATION_CONDITION_READ, {1'b0, i_op_cond});
            if (i % 3 == 2) begin
                query(status_pkg::CMD_STD_EVENT_READ_CLEAR, std_ev);
                std_ev = 8'h00;
                query(status_pkg::CMD_OPERATION_EVENT_READ_CLEAR, op_ev);
                op_ev = 8'h00;
            end
        end
        pulse(3'h7);
        cond(7'h00);
        cond(7'h7F);
        send(status_pkg::CMD_CLEAR_STATUS, 8'h00);
        {std_ev, op_ev} = '0;
        i_msg_available <= 1'b0;
        query(status_pkg::CMD_STATUS_BYTE_READ, 8'h00);
        query(status_pkg::CMD_STD_EVENT_READ_CLEAR, 8'h00);
        query(status_pkg::CMD_OPERATION_EVENT_READ_CLEAR, 8'h00);
        send(status_pkg::CMD_OP_COMPLETE_ARM, 8'h00);
        repeat (5) @(posedge i_clk);
        query(status_pkg::CMD_STD_EVENT_READ_CLEAR, 8'h00);
        i_ops_idle <= 1'b1;
        repeat (3) @(posedge i_clk);
        query(status_pkg::CMD_STD_EVENT_READ_CLEAR, 8'h01);
        query(status_pkg::CMD_STD_EVENT_READ_CLEAR, 8'h00);
        send(status_pkg::CMD_SRQ_ENABLE_WRITE, 8'h20);
        send(status_pkg::CMD_STD_ENABLE_WRITE, 8'h20);
        {sre, ese} = 16'h2020;
        pulse(3'h4);
        @(posedge i_clk);
        #1;
        chk_val({7'h00, o_srq}, 8'h01);
        wait_poll(8'h60);
        pulse(3'h4);
        repeat (8) @(posedge i_clk);
        #1;
        chk_val({7'h00, o_srq}, 8'h00);
        query(status_pkg::CMD_STATUS_BYTE_READ, 8'h60);
        query(status_pkg::CMD_STD_EVENT_READ_CLEAR, 8'h20);
        std_ev = 8'h00;
        query(status_pkg::CMD_STATUS_BYTE_READ, 8'h00);
        pulse(3'h4);
        wait_poll(8'h60);
        test_done();
    end
endmodule

`default_nettype wire
